//--- design/rsc_reset_source_control.sv
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`include "rsc_cfg.svh"
// Overview of operation
// [R1] four threshold codes select lvr level
// [R2] bad threshold code: delayed reset, restore
// [R3] qualified low voltage resets; threshold kept
// [R4] width field chooses 8/32/64/128 osc periods
// [R5] width register upper six bits read zero
// [R6] low voltage cause flag, software clears
// [R7] threshold fault flag, software clears
// [R8] cause register upper four bits zero
// [R9] 55h to flash control one resets
// [R10] running watchdog timeout resets, restores threshold, sets timeout
// [R11] sleeping watchdog timeout: pc, sp, flags
// [R12] status flags per reset kind
// [R13] power-on sets system defaults
// [R14] reset loads guard, threshold, wdt control
// [R15] bad guard code: delayed reset, flag
// [R16] bad wdt enable code: delayed reset
// [R17] low voltage detect off in sleep
// [R18] soft reset delay is parameter
module rsc_reset_source_control #(
	parameter int SOFT_DELAY = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire rsc_pkg::rsc_bus_t bus,
	output logic [7:0] rdata,
	output logic irq,
	input wire logic low_speed_internal_osc_tick,
	input wire logic low_voltage,
	input wire logic wdt_timeout,
	input wire logic sleep_mode,
	output logic [1:0] lvr_level,
	output logic wdt_enable,
	output logic sys_reset,
	output logic pc_sp_clear
);
	// ========================================
	// elaboration checks
	if (SOFT_DELAY < 1 || SOFT_DELAY > 255) begin : g_chk
		$error("SOFT_DELAY out of range");
	end

	// ========================================
	// decode functions
	function automatic logic th_valid(input logic [7:0] c);
		th_valid = (c == `RSC_TH_CODE0) || (c == `RSC_TH_CODE1) ||
			(c == `RSC_TH_CODE2) || (c == `RSC_TH_CODE3);
	endfunction

	function automatic logic [1:0] th_level(input logic [7:0] c);
		if (c == `RSC_TH_CODE1) begin
			th_level = 2'h1;
		end else if (c == `RSC_TH_CODE2) begin
			th_level = 2'h2;
		end else if (c == `RSC_TH_CODE3) begin
			th_level = 2'h3;
		end else begin
			th_level = 2'h0;
		end
	endfunction

	logic [7:0] thresh_r;
	logic [1:0] width_r;
	logic [3:0] cause_r;
	logic [7:0] guard_r;
	logic [7:0] watchdog_control_register_r;
	logic timeout_r;
	logic powerdown_r;
	logic [3:0] irq_stat_r;
	logic [3:0] irq_mask_r;
	logic [7:0] qual_cnt_r;
	logic [7:0] soft_cnt_r;
	logic [7:0] rdata_r;
	logic sys_reset_r;
	logic pc_sp_clear_r;
	logic por_done_r;
	rsc_pkg::rsc_kind_t kind_r;

	// ========================================
	// fault and event detection
	wire th_bad = !th_valid(thresh_r); // R1
	wire guard_bad = (guard_r != `RSC_GUARD_OK0) && (guard_r != `RSC_GUARD_OK1); // R15
	wire [4:0] we_code = watchdog_control_register_r[7:3];
	wire wdt_bad = (we_code != `RSC_WDT_EN) && (we_code != `RSC_WDT_DIS); // R16
	wire soft_bad = th_bad || guard_bad || wdt_bad;
	wire soft_fire = soft_bad && (soft_cnt_r == 8'(SOFT_DELAY - 1)); // R18
	wire lv_active = low_voltage && !sleep_mode; // R17
	wire [7:0] qual_lim = (width_r == 2'h0) ? `RSC_QW0 :
		(width_r == 2'h1) ? `RSC_QW1 :
		(width_r == 2'h2) ? `RSC_QW2 : `RSC_QW3; // R4
	// counts more than lim-1 ticks: fires between lim-1 and lim periods
	wire lvr_fire = lv_active && low_speed_internal_osc_tick && (qual_cnt_r == qual_lim - 8'h01); // R3
	wire wdt_run = wdt_timeout && !sleep_mode; // R10
	wire wdt_sleep = wdt_timeout && sleep_mode; // R11
	wire flash_fire = bus.wr && (bus.addr == `RSC_ADDR_FLASH1) &&
		(bus.wdata == `RSC_FLASH_RST_CODE); // R9
	wire full_rst = soft_fire || lvr_fire || wdt_run || flash_fire;

	// ========================================
	// register write decode
	wire wr_th = bus.wr && (bus.addr == `RSC_ADDR_THRESH);
	wire wr_wd = bus.wr && (bus.addr == `RSC_ADDR_WIDTH);
	wire wr_ca = bus.wr && (bus.addr == `RSC_ADDR_CAUSE);
	wire wr_gu = bus.wr && (bus.addr == `RSC_ADDR_GUARD);
	wire wr_wt = bus.wr && (bus.addr == `RSC_ADDR_WATCHDOG_CONTROL_REGISTER);
	wire wr_mk = bus.wr && (bus.addr == `RSC_ADDR_IRQ_MASK);
	wire rd_is = bus.rd && (bus.addr == `RSC_ADDR_IRQ_STAT);

	// cause bits: set wins over software clear
	wire [3:0] cause_set;
	assign cause_set[`RSC_BIT_WRF] = soft_fire && wdt_bad;
	assign cause_set[`RSC_BIT_LRF] = soft_fire && th_bad; // R7
	assign cause_set[`RSC_BIT_LOW_VOLTAGE_CAUSE_FLAG] = lvr_fire; // R6
	assign cause_set[`RSC_BIT_GUARD_FAULT_FLAG] = soft_fire && guard_bad; // R15
	// write of zero clears, write of one keeps
	wire [3:0] cause_keep = wr_ca ? (cause_r & bus.wdata[3:0]) : cause_r;
	wire [3:0] cause_nxt = cause_keep | cause_set;

	// ========================================
	// read mux, registered for next-cycle data
	wire [7:0] rd_mux;
	assign rd_mux =
		(bus.addr == `RSC_ADDR_THRESH) ? thresh_r :
		(bus.addr == `RSC_ADDR_WIDTH) ? {6'h00, width_r} : // R5
		(bus.addr == `RSC_ADDR_CAUSE) ? {4'h0, cause_r} : // R8
		(bus.addr == `RSC_ADDR_GUARD) ? guard_r :
		(bus.addr == `RSC_ADDR_WATCHDOG_CONTROL_REGISTER) ? watchdog_control_register_r :
		(bus.addr == `RSC_ADDR_STATUS) ? {6'h00, timeout_r, powerdown_r} :
		(bus.addr == `RSC_ADDR_IRQ_STAT) ? {4'h0, irq_stat_r} :
		(bus.addr == `RSC_ADDR_IRQ_MASK) ? {4'h0, irq_mask_r} : 8'h00;

	// ========================================
	// power-on and cause tracking
	always_ff @(posedge clk) begin
		if (!resetn) begin
			por_done_r <= 1'b0;
			kind_r <= rsc_pkg::RSC_POR_FULL;
		end else if (clk_en) begin
			por_done_r <= 1'b1;
			if (full_rst) begin
				kind_r <= lvr_fire ? rsc_pkg::RSC_LVR :
					wdt_run ? rsc_pkg::RSC_WDT_RUN : rsc_pkg::RSC_SOFT;
			end else if (wdt_sleep) begin
				kind_r <= rsc_pkg::RSC_WDT_SLEEP;
			end else begin
				kind_r <= rsc_pkg::RSC_NONE;
			end
		end
	end

	// ========================================
	// guard-type registers; full resets reload defaults, except that lvr keeps the threshold
	always_ff @(posedge clk) begin
		if (!resetn) begin
			thresh_r <= `RSC_THRESH_RST; // R14
			guard_r <= `RSC_GUARD_RST;
			watchdog_control_register_r <= `RSC_WATCHDOG_CONTROL_REGISTER_RST;
			width_r <= `RSC_WIDTH_RST;
		end else if (clk_en) begin
			if (full_rst) begin
				// lvr keeps threshold; bad-code reset restores it
				thresh_r <= lvr_fire ? thresh_r : `RSC_THRESH_RST; // R2 R3 R14
				guard_r <= `RSC_GUARD_RST; // R14
				watchdog_control_register_r <= `RSC_WATCHDOG_CONTROL_REGISTER_RST;
				width_r <= `RSC_WIDTH_RST;
			end else begin
				if (wr_th) thresh_r <= bus.wdata;
				if (wr_gu) guard_r <= bus.wdata;
				if (wr_wt) watchdog_control_register_r <= bus.wdata;
				if (wr_wd) width_r <= bus.wdata[1:0];
			end
		end
	end

	// ========================================
	// cause flags: unknown at power-on for lvr bit, chosen zero
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cause_r <= 4'h0;
		end else if (clk_en) begin
			cause_r <= cause_nxt; // R6 R7
		end
	end

	// ========================================
	// timeout and power-down status
	always_ff @(posedge clk) begin
		if (!resetn) begin
			timeout_r <= 1'b0; // R12
			powerdown_r <= 1'b0;
		end else if (clk_en) begin
			if (wdt_sleep) begin
				timeout_r <= 1'b1; // R11
				powerdown_r <= 1'b1;
			end else if (wdt_run) begin
				timeout_r <= 1'b1; // R10 R12
			end
		end
	end

	// ========================================
	// qualify and soft-delay counters
	always_ff @(posedge clk) begin
		if (!resetn) begin
			qual_cnt_r <= 8'h00;
			soft_cnt_r <= 8'h00;
		end else if (clk_en) begin
			// glitches shorter than lim-1 periods never reach the limit
			if (!lv_active || lvr_fire) begin
				qual_cnt_r <= 8'h00;
			end else if (low_speed_internal_osc_tick) begin
				qual_cnt_r <= qual_cnt_r + 8'h01; // R3
			end
			if (!soft_bad || soft_fire) begin
				soft_cnt_r <= 8'h00;
			end else begin
				soft_cnt_r <= soft_cnt_r + 8'h01; // R18
			end
		end
	end

	// ========================================
	// interrupt status, cleared by read, set wins
	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq_stat_r <= 4'h0;
			irq_mask_r <= 4'h0;
			irq <= 1'b0;
		end else if (clk_en) begin
			irq_stat_r <= (rd_is ? 4'h0 : irq_stat_r) | cause_set;
			if (wr_mk) irq_mask_r <= bus.wdata[3:0];
			irq <= |(irq_stat_r & irq_mask_r);
		end
	end

	// ========================================
	// outputs, all registered
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdata_r <= 8'h00;
			sys_reset_r <= 1'b1; // R13
			pc_sp_clear_r <= 1'b1;
			lvr_level <= 2'h0;
			wdt_enable <= 1'b1;
		end else if (clk_en) begin
			rdata_r <= bus.rd ? rd_mux : 8'h00;
			// first cycle out of reset still shows the power-on reset
			sys_reset_r <= full_rst || !por_done_r; // R9 R10 R13
			pc_sp_clear_r <= full_rst || wdt_sleep || !por_done_r; // R11
			lvr_level <= th_level(thresh_r); // R1
			wdt_enable <= (we_code == `RSC_WDT_EN); // R16
		end
	end

	assign rdata = rdata_r;
	assign sys_reset = sys_reset_r;
	assign pc_sp_clear = pc_sp_clear_r;
endmodule // rsc_reset_source_control

//--- design/rsc_cfg.svh
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH
// ========================================
// register offsets
`define RSC_ADDR_THRESH 4'h0
`define RSC_ADDR_WIDTH 4'h1
`define RSC_ADDR_CAUSE 4'h2
`define RSC_ADDR_GUARD 4'h3
`define RSC_ADDR_WATCHDOG_CONTROL_REGISTER 4'h4
`define RSC_ADDR_FLASH1 4'h5
`define RSC_ADDR_STATUS 4'h6
`define RSC_ADDR_IRQ_STAT 4'h7
`define RSC_ADDR_IRQ_MASK 4'h8
// ========================================
// reset values and codes
`define RSC_THRESH_RST 8'h55
`define RSC_GUARD_RST 8'h55
`define RSC_WATCHDOG_CONTROL_REGISTER_RST 8'h53
`define RSC_WIDTH_RST 2'h1
`define RSC_TH_CODE0 8'h55
`define RSC_TH_CODE1 8'h33
`define RSC_TH_CODE2 8'h99
`define RSC_TH_CODE3 8'haa
`define RSC_GUARD_OK0 8'h55
`define RSC_GUARD_OK1 8'haa
`define RSC_WDT_EN 5'h0a
`define RSC_WDT_DIS 5'h15
`define RSC_FLASH_RST_CODE 8'h55
// ========================================
// cause register bit positions
`define RSC_BIT_WRF 0
`define RSC_BIT_LRF 1
`define RSC_BIT_LOW_VOLTAGE_CAUSE_FLAG 2
`define RSC_BIT_GUARD_FAULT_FLAG 3
// qualify widths in low-speed osc periods (upper figure of each range)
`define RSC_QW0 8'h08
`define RSC_QW1 8'h20
`define RSC_QW2 8'h40
`define RSC_QW3 8'h80
`endif

//--- design/rsc_pkg.sv
package rsc_pkg;
	// ========================================
	// register bus request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} rsc_bus_t;
	// reset cause kinds
	typedef enum logic [2:0] {
		RSC_NONE,
		RSC_POR_FULL,
		RSC_LVR,
		RSC_WDT_RUN,
		RSC_WDT_SLEEP,
		RSC_SOFT
	} rsc_kind_t;
endpackage

//--- verification/rsc_props.sv
`timescale 1ns/100ps
`include "rsc_cfg.svh"
// ========================================
// port checks for the reset source block
module rsc_props (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire rsc_pkg::rsc_bus_t bus,
	input wire logic [7:0] rdata,
	input wire logic irq,
	input wire logic low_speed_internal_osc_tick,
	input wire logic low_voltage,
	input wire logic wdt_timeout,
	input wire logic sleep_mode,
	input wire logic [1:0] lvr_level,
	input wire logic wdt_enable,
	input wire logic sys_reset,
	input wire logic pc_sp_clear
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// requests that the block really takes
	wire rd_q = bus.rd && clk_en;
	wire wr_q = bus.wr && clk_en;
	property p_width_hi;
		rd_q && bus.addr == `RSC_ADDR_WIDTH |=> rdata[7:2] == 6'h00;
	endproperty
	a_width_hi: assert property (p_width_hi) else $error("width upper bits set");
	property p_cause_hi;
		rd_q && bus.addr == `RSC_ADDR_CAUSE |=> rdata[7:4] == 4'h0;
	endproperty
	a_cause_hi: assert property (p_cause_hi) else $error("cause upper bits set");
	property p_level;
		wr_q && bus.addr == `RSC_ADDR_THRESH && bus.wdata == `RSC_TH_CODE3 |=> ##[0:2] lvr_level == 2'h3;
	endproperty
	a_level: assert property (p_level) else $error("top level not chosen");
	property p_flash;
		wr_q && bus.addr == `RSC_ADDR_FLASH1 && bus.wdata == `RSC_FLASH_RST_CODE |=> sys_reset;
	endproperty
	a_flash: assert property (p_flash) else $error("flash reset missing");
	property p_wdt_on;
		wr_q && bus.addr == `RSC_ADDR_WATCHDOG_CONTROL_REGISTER && bus.wdata == `RSC_WATCHDOG_CONTROL_REGISTER_RST |=> ##[0:2] wdt_enable;
	endproperty
	a_wdt_on: assert property (p_wdt_on) else $error("watchdog not enabled");
	property p_run_wdt;
		!sleep_mode && wdt_timeout && clk_en |=> ##[0:2] sys_reset;
	endproperty
	a_run_wdt: assert property (p_run_wdt) else $error("run timeout no reset");
	property p_sleep_wdt;
		sleep_mode && wdt_timeout && clk_en |=> ##[0:2] (pc_sp_clear && !sys_reset);
	endproperty
	a_sleep_wdt: assert property (p_sleep_wdt) else $error("sleep timeout wrong");
	// a full reset always restarts program flow too
	property p_full_pc;
		sys_reset |-> pc_sp_clear;
	endproperty
	a_full_pc: assert property (p_full_pc) else $error("full reset kept pc");
endmodule // rsc_props
bind rsc_reset_source_control rsc_props u_props (.clk, .resetn, .clk_en, .bus, .rdata, .irq,
	.low_speed_internal_osc_tick, .low_voltage, .wdt_timeout, .sleep_mode, .lvr_level, .wdt_enable, .sys_reset,
	.pc_sp_clear);

//--- verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	logic clk = 0;
	logic resetn = 0;
	logic low_speed_internal_osc_tick = 0;
	logic low_voltage = 0;
	logic wdt_timeout = 0;
	logic sleep_mode = 0;
	rsc_pkg::rsc_bus_t bus = '0;
	logic [7:0] rdata;
	logic irq, wdt_enable, sys_reset, pc_sp_clear;
	logic [1:0] lvr_level;
	int bad_count = 0;
	int num_checks = 0;
	int cycles = 0;
	// ========================================
	// clock, block, hang guard
	always #2.5 clk = ~clk;
	rsc_reset_source_control #(.SOFT_DELAY(2)) dut_u (.clk, .resetn, .clk_en(1'b1), .bus,
		.rdata, .irq, .low_speed_internal_osc_tick, .low_voltage, .wdt_timeout, .sleep_mode, .lvr_level,
		.wdt_enable, .sys_reset, .pc_sp_clear);
	// far above the few thousand cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			tally_and_finish;
		end
	end
	task tally_and_finish;
		if (bad_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	// ========================================
	// bus cycles and waits
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk) bus <= '0;
	endtask
	task rc(input logic [3:0] a, input logic [7:0] e, input string n);
		@(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk) bus <= '0;
		#1 chk(n, rdata, e);
	endtask
	task pulse(input bit pc, input string n);
		for (int i = 0; i < 100 && (pc ? pc_sp_clear : sys_reset) !== 1'b1; i++) @(negedge clk);
		chk(n, {7'h00, pc ? pc_sp_clear : sys_reset}, 8'h01);
		repeat (4) @(posedge clk);
	endtask
	task tmo;
		@(posedge clk) wdt_timeout <= 1'b1;
		@(posedge clk) wdt_timeout <= 1'b0;
	endtask
	// ticks counted until reset shows, zero if it never does
	task lv(input logic [7:0] e, input string n);
		int t;
		logic seen;
		seen = 0;
		t = 0;
		@(posedge clk) low_voltage <= 1'b1;
		while (!seen && t < 140) begin
			@(posedge clk) low_speed_internal_osc_tick <= 1'b1;
			@(posedge clk) low_speed_internal_osc_tick <= 1'b0;
			t++;
			repeat (5) @(negedge clk) seen |= sys_reset;
		end
		@(posedge clk) low_voltage <= 1'b0;
		chk(n, seen ? t[7:0] : 8'h00, e);
		repeat (4) @(posedge clk);
	endtask
	// ========================================
	// scenarios
	task t_defaults;
		rc(4'h0, 8'h55, "thresh");
		rc(4'h1, 8'h01, "width");
		rc(4'h3, 8'h55, "guard");
		rc(4'h4, 8'h53, "watchdog_control_register");
		rc(4'h6, 8'h00, "status");
		rc(4'h9, 8'h00, "unmapped");
		chk("wdt_en", {7'h00, wdt_enable}, 8'h01);
	endtask
	task t_levels;
		logic [7:0] c [4];
		c = '{8'h55, 8'h33, 8'h99, 8'haa};
		for (int i = 0; i < 4; i++) begin
			wr(4'h0, c[i]);
			repeat (2) @(negedge clk);
			chk("level", {6'h00, lvr_level}, i[7:0]);
		end
	endtask
	// bad codes in all three guarded registers
	task t_bad_codes;
		logic [3:0] a [3];
		a = '{4'h0, 4'h3, 4'h4};
		for (int i = 0; i < 3; i++) begin
			wr(a[i], 8'h00);
			pulse(0, "soft reset");
		end
		rc(4'h0, 8'h55, "thresh back");
		wr(4'h2, 8'hff);
		rc(4'h2, 8'h0b, "faults");
		wr(4'h2, 8'h00);
		rc(4'h2, 8'h00, "faults clear");
		wr(4'h3, 8'haa);
		rc(4'h3, 8'haa, "guard alt");
		wr(4'h4, 8'hab);
		// enable output follows the register one edge later
		repeat (2) @(negedge clk);
		chk("wdt_off", {7'h00, wdt_enable}, 8'h00);
		wr(4'h4, 8'h53);
	endtask
	task t_lvr;
		rc(4'h7, 8'h0b, "irq_stat");
		wr(4'h0, 8'h33);
		wr(4'h1, 8'h00);
		lv(8'h08, "short width");
		rc(4'h0, 8'h33, "thresh kept");
		rc(4'h2, 8'h04, "lv flag");
		chk("irq masked", {7'h00, irq}, 8'h00);
		wr(4'h8, 8'h04);
		repeat (2) @(negedge clk);
		chk("irq", {7'h00, irq}, 8'h01);
		rc(4'h7, 8'h04, "irq_stat");
		repeat (2) @(negedge clk);
		chk("irq cleared", {7'h00, irq}, 8'h00);
		wr(4'h1, 8'h03);
		lv(8'h80, "long width");
		@(posedge clk) sleep_mode <= 1'b1;
		wr(4'h1, 8'h00);
		lv(8'h00, "sleep lv");
	endtask
	task t_wdt;
		wr(4'h0, 8'h99);
		tmo;
		pulse(1, "sleep wdt");
		rc(4'h6, 8'h03, "sleep status");
		rc(4'h0, 8'h99, "sleep kept");
		@(posedge clk) sleep_mode <= 1'b0;
		tmo;
		pulse(0, "run wdt");
		rc(4'h0, 8'h55, "run thresh");
		rc(4'h6, 8'h03, "run status");
		wr(4'h0, 8'h99);
		wr(4'h5, 8'h55);
		pulse(0, "flash reset");
		rc(4'h0, 8'h55, "flash thresh");
	endtask
	// ========================================
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
		t_defaults;
		t_levels;
		t_bad_codes;
		t_lvr;
		t_wdt;
		tally_and_finish;
	end
endmodule // tb_top
